//--- rtl/rtccs_ctrl.v
/*
  Control register 1 of a serial real-time clock: second snap, busy, carry
  gate with deferred second, oscillator halt flag, alarm and periodic flags,
  open-drain interrupt pin, and the serial slave that reaches the register.
  Assumes counters, alarm compare and periodic generator live outside and
  exchange one-cycle pulses and levels on clk; ce, sclk, sio_in and osc_ok
  arrive asynchronously and are synchronised here.
  The host lets SIO go while sio_oe is high. Every carry and every snap
  opens a busy window of BUSY_CYC cycles; a new one re-arms it, so busy
  may stretch but each window stays within its bound.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rtccs_defs.vh"

// How it works
// R1: Register Eh: D3 periodic, D2 alarm, D1, D0
// R2: Snap write raises busy at most 122.1 us
// R3: Snap deferred until carry enable returns
// R4: Snap clears sub-seconds, seconds 30+ bump minute
// R5: Busy reads 1 during carry or adjustment
// R6: Host writes counters only while not busy
// R7: Host clears carry enable, checks busy first
// R8: Host may reread counters with carry enabled
// R9: Chip select low sets carry enable
// R10: Held carry applied as one second later
// R11: Host keeps carry enable short or reads enabled
// R12: Halt flag sets while deselected, stays set
// R13: Halt sensing frozen while chip selected
// R14: Register write with oscillator running clears halt
// R15: Alarm flag follows armed match, pulls interrupt
// R16: Periodic flag writable only in level mode
// R17: Mode select: 0 pulse, 1 level
// R18: Register reachable regardless of bank select
// R19: Busy sampled stably at data phase start
module rtccs_ctrl #(
  parameter integer BUSY_CYC = `RTCCS_BUSY_CYC
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire sclk,
  input wire sio_in,
  output reg sio_out,
  output reg sio_oe,
  input wire osc_ok,
  input wire sec_tick,
  input wire seconds_ge30,
  input wire alarm_arm,
  input wire alarm_match,
  input wire irq_mode_sel,
  input wire periodic_event,
  input wire periodic_pulse,
  output reg sec_inc,
  output reg snap_clear,
  output reg snap_min_inc,
  output reg carry_enable,
  output reg osc_halt_flag,
  output reg alarm_match_flag,
  output reg periodic_irq_flag,
  output reg counter_update_pending,
  output reg irq_out_n,
  output reg irq_oe
);

  localparam [2:0] ST_HDR = 3'b001;
  localparam [2:0] ST_DATA = 3'b010;
  localparam [2:0] ST_END = 3'b100;
  // Last bit index of each frame phase, taken from the frame widths
  localparam integer HDR_LAST = `RTCCS_HDR_BITS - 1;
  localparam integer DATA_LAST = `RTCCS_DATA_BITS - 1;
  localparam [2:0] HDR_LAST_CNT = HDR_LAST[2:0];
  localparam [2:0] DATA_LAST_CNT = DATA_LAST[2:0];

  // Two-stage synchronisers; first stages feed only the second
  reg ce_m;
  reg ce_s;
  reg sclk_m;
  reg sclk_s;
  reg sclk_d;
  reg sio_m;
  reg sio_s;
  reg osc_m;
  reg osc_s;

  reg [2:0] state;
  reg [2:0] bit_cnt;
  reg [4:0] hdr;
  reg [3:0] wdata;
  reg [3:0] rd_snap;
  reg snap_pending;
  reg carry_pending;
  reg busy_start;
  wire busy_raw;
  wire sclk_rise;
  wire sclk_fall;
  wire [4:0] next_hdr;
  wire [3:0] next_wdata;
  wire ctrl_write;
  wire alarm_hit;
  wire irq_req;

  // Edge of the synchronised serial clock, seen only while selected
  function sclk_edge;
    input sel;
    input now;
    input prev;
    input rising;
    begin
      sclk_edge = sel & (now == rising) & (prev != rising);
    end
  endfunction

  function addr_is_ctrl;
    input [3:0] addr;
    begin
      // Bank select plays no part in this decode
      addr_is_ctrl = (addr == `RTCCS_CTRL1_ADDR); // R18
    end
  endfunction

  always @(posedge clk) begin
    if (rst) begin
      ce_m <= 1'b0;
      ce_s <= 1'b0;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      sio_m <= 1'b0;
      sio_s <= 1'b0;
      osc_m <= 1'b0;
      osc_s <= 1'b0;
    end else begin
      ce_m <= ce;
      ce_s <= ce_m;
      sclk_m <= sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      sio_m <= sio_in;
      sio_s <= sio_m;
      osc_m <= osc_ok;
      osc_s <= osc_m;
    end
  end

  assign sclk_rise = sclk_edge(ce_s, sclk_s, sclk_d, 1'b1);
  assign sclk_fall = sclk_edge(ce_s, sclk_s, sclk_d, 1'b0);
  assign alarm_hit = alarm_arm & alarm_match;
  // Level mode drives from the flag, pulse mode from the waveform
  assign irq_req = alarm_hit | (irq_mode_sel ? periodic_irq_flag : periodic_pulse); // R17
  assign next_hdr = {hdr[3:0], sio_s};
  assign next_wdata = {wdata[2:0], sio_s};
  // Header bit 4 set means a write
  assign ctrl_write = (state == ST_DATA) & sclk_rise & hdr[4] & addr_is_ctrl(hdr[3:0])
                      & (bit_cnt == DATA_LAST_CNT);

  rtccs_busy_timer #(
    .CYCLES(BUSY_CYC)
  ) u_busy (
    .clk(clk),
    .rst(rst),
    .start(busy_start),
    .busy(busy_raw)
  );

  // Serial frame sequencer
  always @(posedge clk) begin
    if (rst) begin
      state <= ST_HDR;
      bit_cnt <= 3'd0;
      hdr <= 5'h00;
      wdata <= 4'h0;
      rd_snap <= 4'h0;
      sio_out <= 1'b0;
      sio_oe <= 1'b0;
    end else if (!ce_s) begin
      // Deselect aborts a frame; a partial write never lands
      state <= ST_HDR;
      bit_cnt <= 3'd0;
      sio_out <= 1'b0;
      sio_oe <= 1'b0;
    end else begin
      case (state)
        ST_HDR: begin
          if (sclk_rise) begin
            hdr <= next_hdr;
            if (bit_cnt == HDR_LAST_CNT) begin
              bit_cnt <= 3'd0;
              state <= ST_DATA;
              if (!next_hdr[4] && addr_is_ctrl(next_hdr[3:0])) begin
                // Frozen once so a busy edge mid-read cannot tear the word
                rd_snap <= {periodic_irq_flag, alarm_match_flag, osc_halt_flag,
                            counter_update_pending}; // R19 R1
                sio_out <= periodic_irq_flag;
                sio_oe <= 1'b1;
              end
            end else begin
              bit_cnt <= bit_cnt + 3'd1;
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            wdata <= next_wdata;
            if (bit_cnt == DATA_LAST_CNT) begin
              state <= ST_END;
            end
            bit_cnt <= bit_cnt + 3'd1;
          end else if (sclk_fall && sio_oe) begin
            sio_out <= rd_snap[3 - bit_cnt[1:0]];
          end
        end
        ST_END: begin
          if (sclk_fall) begin
            sio_oe <= 1'b0;
          end
        end
        default: begin
          state <= ST_HDR;
        end
      endcase
    end
  end

  // Carry gate, snap and busy
  always @(posedge clk) begin
    if (rst) begin
      carry_enable <= 1'b1;
      snap_pending <= 1'b0;
      carry_pending <= 1'b0;
      sec_inc <= 1'b0;
      snap_clear <= 1'b0;
      snap_min_inc <= 1'b0;
      busy_start <= 1'b0;
      counter_update_pending <= 1'b0;
    end else begin
      sec_inc <= 1'b0;
      snap_clear <= 1'b0;
      snap_min_inc <= 1'b0;
      busy_start <= 1'b0;
      counter_update_pending <= busy_raw; // R5
      if (!ce_s) begin
        carry_enable <= 1'b1; // R9
      end else if (ctrl_write) begin
        carry_enable <= next_wdata[`RTCCS_BIT_CARRY];
      end
      if (ctrl_write && next_wdata[`RTCCS_BIT_SNAP]) begin
        snap_pending <= 1'b1;
      end else if (snap_pending && carry_enable) begin
        // Held while carry is disabled
        snap_pending <= 1'b0; // R3
        snap_clear <= 1'b1; // R4
        snap_min_inc <= seconds_ge30; // R4
        busy_start <= 1'b1; // R2
      end
      if (sec_tick && (!carry_enable || snap_pending)) begin
        // Several held ticks still yield one second; a tick that meets
        // a pending snap is held too, not lost
        carry_pending <= 1'b1; // R10
      end else if (carry_enable && (sec_tick || carry_pending) && !snap_pending) begin
        carry_pending <= 1'b0;
        sec_inc <= 1'b1; // R10
        busy_start <= 1'b1; // R5
      end
    end
  end

  // Oscillator halt sensing
  always @(posedge clk) begin
    if (rst) begin
      osc_halt_flag <= 1'b1;
    end else if (!ce_s && !osc_s) begin // R13
      osc_halt_flag <= 1'b1; // R12
    end else if (ctrl_write && osc_s) begin
      osc_halt_flag <= 1'b0; // R14
    end
    // Otherwise held, including while selected R13
  end

  // Alarm and periodic flags, open-drain interrupt
  always @(posedge clk) begin
    if (rst) begin
      alarm_match_flag <= 1'b0;
      periodic_irq_flag <= 1'b0;
      irq_out_n <= 1'b1;
      irq_oe <= 1'b0;
    end else begin
      alarm_match_flag <= alarm_hit; // R15
      if (irq_mode_sel && periodic_event) begin
        // Event wins over a clearing write in the same cycle
        periodic_irq_flag <= 1'b1; // R17
      end else if (ctrl_write && irq_mode_sel) begin
        periodic_irq_flag <= next_wdata[`RTCCS_BIT_PIRQ]; // R16
      end
      // Open drain: enable high exactly while the pin is pulled low
      if (irq_req) begin
        irq_out_n <= 1'b0; // R15 R17
        irq_oe <= 1'b1;
      end else begin
        irq_out_n <= 1'b1;
        irq_oe <= 1'b0;
      end
    end
  end

endmodule // rtccs_ctrl

`default_nettype wire

//--- rtl/rtccs_defs.vh
/*
  Constants of the control and status register block of the serial clock.
  Assumes a 40 MHz system clock; included by the design files by bare name.
*/
`ifndef RTCCS_DEFS_VH
`define RTCCS_DEFS_VH

// Register map
`define RTCCS_ADDR_W 4
`define RTCCS_CTRL1_ADDR 4'he
`define RTCCS_CTRL1_RESET 4'h2

// Field positions of the control register
`define RTCCS_BIT_PIRQ 3
`define RTCCS_BIT_ALARM 2
`define RTCCS_BIT_CARRY 1
`define RTCCS_BIT_SNAP 0

// Serial frame: one direction bit, four address bits, four data bits
`define RTCCS_HDR_BITS 5
`define RTCCS_DATA_BITS 4

// Timing
`define RTCCS_CLK_MHZ 40
`define RTCCS_BUSY_TIME_NS 122100
`define RTCCS_BUSY_CYC ((`RTCCS_BUSY_TIME_NS * `RTCCS_CLK_MHZ) / 1000)

`endif

//--- rtl/rtccs_busy_timer.v
/*
  Busy window timer: a start pulse opens a window of a fixed cycle count.
  Assumes start is a one-cycle pulse on clk; a new start re-arms the window.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rtccs_defs.vh"

module rtccs_busy_timer #(
  parameter integer CYCLES = `RTCCS_BUSY_CYC
) (
  input wire clk,
  input wire rst,
  input wire start,
  output reg busy
);

  reg [15:0] count;

  always @(posedge clk) begin
    if (rst) begin
      count <= 16'h0000;
      busy <= 1'b0;
    end else if (start) begin
      count <= CYCLES[15:0] - 16'h0001;
      busy <= 1'b1;
    end else if (count != 16'h0000) begin
      count <= count - 16'h0001;
    end else begin
      // Window never exceeds the count, so each window stays within its bound
      busy <= 1'b0; // R2
    end
  end

endmodule // rtccs_busy_timer

`default_nettype wire

//--- verif/rtccs_ctrl_sva.sv
/*
  Port checker of the control and status register block.
  Assumes the block's clk and synchronous rst; bound to every instance.
*/
`timescale 1ns/100ps
`default_nettype none
module rtccs_ctrl_sva #(
  parameter integer BUSY_CYC = 20
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire alarm_arm,
  input wire alarm_match,
  input wire irq_mode_sel,
  input wire periodic_pulse,
  input wire sec_inc,
  input wire snap_clear,
  input wire snap_min_inc,
  input wire carry_enable,
  input wire alarm_match_flag,
  input wire periodic_irq_flag,
  input wire counter_update_pending,
  input wire irq_out_n,
  input wire irq_oe,
  input wire sio_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] run;
  logic start_d;
  // Restarts one cycle after each start pulse, where a re-armed window
  // is first seen, so a tail of the old window is not counted twice
  always @(posedge clk) begin
    start_d <= sec_inc || snap_clear;
    if (rst || start_d)
      run <= 16'h0;
    else if (counter_update_pending)
      run <= run + 16'h1;
  end
  sequence busy_soon;
    ##2 counter_update_pending;
  endsequence
  alarm_flag_a: assert property ($past(rst)
    || alarm_match_flag == $past(alarm_arm && alarm_match))
    else $error("alarm flag wrong");
  irq_alarm_a: assert property (alarm_match_flag |-> !irq_out_n && irq_oe)
    else $error("alarm not on pin");
  irq_pulse_a: assert property (!irq_mode_sel && periodic_pulse |=> !irq_out_n)
    else $error("pulse mode not on pin");
  irq_level_a: assert property (irq_mode_sel && periodic_irq_flag |=> !irq_out_n)
    else $error("level flag not on pin");
  irq_off_a: assert property (!(alarm_arm && alarm_match)
    && !(irq_mode_sel ? periodic_irq_flag : periodic_pulse) |=> irq_out_n && !irq_oe)
    else $error("pin not released");
  carry_gate_a: assert property (sec_inc |-> $past(carry_enable))
    else $error("second passed while gated");
  busy_start_a: assert property (sec_inc || snap_clear |-> busy_soon)
    else $error("busy missing");
  busy_len_a: assert property (run <= BUSY_CYC)
    else $error("busy too long");
  snap_gate_a: assert property (snap_clear || snap_min_inc |-> snap_clear && carry_enable)
    else $error("snap out of place");
  deselect_a: assert property (!ce [*6] |-> carry_enable && !sio_oe)
    else $error("deselect state wrong");
endmodule // rtccs_ctrl_sva
bind rtccs_ctrl rtccs_ctrl_sva #(.BUSY_CYC(BUSY_CYC)) chk_u (.*);
`default_nettype wire

//--- verif/rtccs_host.sv
/*
  Host model of the three-wire link: direction, address, data, MSB first.
  Assumes the block's clk; drives on its falling edge, slow serial clock.
*/
`timescale 1ns/100ps
`default_nettype none
module rtccs_host (
  input wire logic clk,
  input wire logic sio_out,
  output var logic ce,
  output var logic sclk,
  output var logic sio_in
);
  initial begin
    ce = 1'b0;
    sclk = 1'b0;
    sio_in = 1'b0;
  end
  task automatic frame(input logic [8:0] bits, output logic [3:0] q);
    int i;
    @(negedge clk) ce = 1'b1;
    for (i = 8; i >= 0; i--) begin
      // Released line toggles so a stale level is never mistaken for data
      // Four clocks low, four high: a 200 ns serial clock
      @(negedge clk) sio_in = (bits[8] || i > 3) ? bits[i] : ~sio_in;
      repeat (3) @(negedge clk);
      if (i < 4)
        q[i] = sio_out;
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    ce = 1'b0;
    repeat (8) @(negedge clk);
  endtask
endmodule // rtccs_host
`default_nettype wire

//--- verif/rtc_control_status_register_bench.sv
/*
  Self-checking bench of rtccs_ctrl with the host model on its link.
  Assumes a shortened busy window of 20 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module rtc_control_status_register_bench;
  logic clk = 0, rst = 1, osc_ok = 1, sec_tick = 0, seconds_ge30 = 0, alarm_arm = 0;
  logic alarm_match = 0, irq_mode_sel = 0, periodic_event = 0, periodic_pulse = 0;
  wire ce, sclk, h_sio, sio_out, sio_oe, sec_inc, snap_clear, snap_min_inc, carry_enable;
  wire osc_halt_flag, alarm_match_flag, periodic_irq_flag, counter_update_pending;
  wire irq_out_n, irq_oe;
  wire sio_w = sio_oe ? sio_out : h_sio;
  int mismatches = 0, checks = 0, n_inc = 0, n_min = 0, n_clr = 0, seed = 19775;
  logic [3:0] q;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    n_inc += sec_inc;
    n_min += snap_min_inc;
    n_clr += snap_clear;
  end
  rtccs_host host_u (.clk, .sio_out, .ce, .sclk, .sio_in(h_sio));
  rtccs_ctrl #(.BUSY_CYC(20)) dut_u (.clk, .rst, .ce, .sclk, .sio_in(sio_w), .sio_out,
    .sio_oe, .osc_ok, .sec_tick, .seconds_ge30, .alarm_arm, .alarm_match, .irq_mode_sel,
    .periodic_event, .periodic_pulse, .sec_inc, .snap_clear, .snap_min_inc, .carry_enable,
    .osc_halt_flag, .alarm_match_flag, .periodic_irq_flag, .counter_update_pending,
    .irq_out_n, .irq_oe);
  task check(input logic [3:0] got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function logic [3:0] reg_exp(input logic p, a, h, b);
    return {p, a, h, b};
  endfunction
  task xfer(input logic w, input logic [3:0] a, d, exp);
    host_u.frame({w, a, d}, q);
    if (!w)
      check(q, exp);
  endtask
  task stop_test;
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    stop_test;
  end
  initial begin
    int b, c;
    repeat (8) @(negedge clk);
    rst = 0;
    repeat (4) @(negedge clk);
    check({carry_enable, osc_halt_flag, irq_out_n, irq_oe}, 4'he);
    xfer(0, 4'he, 4'h0, reg_exp(0, 0, 1, 0));
    xfer(1, 4'he, 4'h2, 4'h0);
    xfer(0, 4'he, 4'h0, reg_exp(0, 0, 0, 0));
    osc_ok = 0;
    repeat (10) @(negedge clk);
    osc_ok = 1;
    xfer(0, 4'he, 4'h0, reg_exp(0, 0, 1, 0));
    b = n_inc;
    fork
      xfer(1, 4'he, 4'h0, 4'h0);
      begin
        wait (carry_enable === 1'b0);
        repeat (2) begin
          @(negedge clk) sec_tick = 1;
          @(negedge clk) sec_tick = 0;
        end
      end
    join
    check(4'(n_inc - b), 4'h1);
    // Carry back on and busy over before the next access samples busy at its header end
    xfer(0, 4'he, 4'h0, reg_exp(0, 0, 0, 0));
    for (int g = 1; g >= 0; g--) begin
      seconds_ge30 = g[0];
      b = n_min;
      c = n_clr;
      // Carry left off when g is 0, so the snap must wait for deselect
      xfer(1, 4'he, {2'b0, g[0], 1'b1}, 4'h0);
      check(counter_update_pending, 1);
      repeat (40) @(negedge clk);
      check(counter_update_pending, 0);
      check(4'(n_min - b), 4'(g));
      check(4'(n_clr - c), 4'h1);
    end
    irq_mode_sel = 1;
    xfer(1, 4'he, 4'h8, 4'h0);
    xfer(0, 4'he, 4'h0, reg_exp(1, 0, 0, 0));
    check(irq_out_n, 0);
    irq_mode_sel = 0;
    xfer(1, 4'he, 4'h0, 4'h0);
    xfer(0, 4'he, 4'h0, reg_exp(1, 0, 0, 0));
    check(irq_out_n, 1);
    irq_mode_sel = 1;
    xfer(1, 4'h7, 4'h0, 4'h0);
    xfer(0, 4'he, 4'h0, reg_exp(1, 0, 0, 0));
    xfer(1, 4'he, 4'h0, 4'h0);
    check(irq_out_n, 1);
    alarm_arm = 1;
    alarm_match = 1;
    xfer(0, 4'he, 4'h0, reg_exp(0, 1, 0, 0));
    check(irq_out_n, 0);
    alarm_match = 0;
    repeat (2) @(negedge clk);
    check(alarm_match_flag, 0);
    repeat (400) @(negedge clk) begin
      {alarm_arm, alarm_match, irq_mode_sel, periodic_pulse, periodic_event} = 5'($random(seed));
      sec_tick = (($random(seed) & 63) == 0);
    end
    sec_tick = 0;
    stop_test;
  end
endmodule // rtc_control_status_register_bench
`default_nettype wire
